/* hdl/iid_decoder.sv */
`timescale 1ns/100ps
`include "iid_cfg.svh"
module iid_decoder
   import iid_pkg::*;
#(
   parameter int DID_WIDTH_DEF = 16,
   parameter int MAX_GUEST_ADDR_WIDTH_DEF = 48
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic dsc_valid_in,
   input wire iid_dsc_t dsc_in,
   output logic dsc_ready_out,
   input wire logic wait_valid_in,
   output logic wait_ready_out,
   output logic wait_done_out,
   output iid_inv_s inv_cmd_out,
   output logic inv_valid_out,
   input wire logic inv_ack_in,
   input wire logic inv_quiesced_in,
   output logic wbf_req_out,
   input wire logic wbf_done_in,
   output logic drain_req_out,
   output logic drain_rd_out,
   output logic drain_wr_out,
   input wire logic drain_done_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (DID_WIDTH_DEF < 1 || DID_WIDTH_DEF > 16) begin : g_bad_did
      $error("Domain width must lie in 1..16");
   end
   if (MAX_GUEST_ADDR_WIDTH_DEF < 13 || MAX_GUEST_ADDR_WIDTH_DEF > 64) begin : g_bad_max_guest_addr_width
      $error("Guest address width must lie in 13..64");
   end

   localparam logic [4:0] DIDW_RST = 5'(DID_WIDTH_DEF);
   localparam logic [6:0] MAX_GUEST_ADDR_WIDTH_RST = 7'(MAX_GUEST_ADDR_WIDTH_DEF);

   // ----------------------------------------
   // Field helpers
   // ----------------------------------------
   // Keep only the reported low domain bits
   function automatic logic [15:0] iid_mask_did(input logic [15:0] domain_identifier,
                                                input logic [4:0] width);
      logic [15:0] m;
      m = '0;
      for (int i = 0; i < 16; i++) begin
         m[i] = (i < int'(width));
      end
      return domain_identifier & m;
   endfunction : iid_mask_did

   // Keep only page bits below the guest address width
   function automatic logic [51:0] iid_mask_addr(input logic [51:0] addr,
                                                 input logic [6:0] max_guest_addr_width);
      logic [51:0] m;
      m = '0;
      for (int i = 0; i < 52; i++) begin
         m[i] = (i + `IID_PAGE_SHIFT < int'(max_guest_addr_width));
      end
      return addr & m;
   endfunction : iid_mask_addr

   // Order that clears every cache with no filter
   function automatic iid_inv_s iid_all();
      iid_inv_s c;
      c = '0;
      c.iotlb_sl = 1'b1;
      c.iotlb_fl = 1'b1;
      c.psc_sl = 1'b1;
      c.psc_fl = 1'b1;
      c.pasid_cache = 1'b1;
      return c;
   endfunction : iid_all

   // Second-level command decode
   function automatic iid_inv_s iid_dec_iotlb(input iid_dsc_t d,
                                              input logic [4:0] didw,
                                              input logic [6:0] max_guest_addr_width);
      iid_inv_s c;
      c = iid_all();
      unique case (d[`IID_GRAN_MSB:`IID_GRAN_LSB])
         `IID_G_10: begin
            c.match_did = 1'b1;
            c.domain_identifier = iid_mask_did(d[`IID_DID_MSB:`IID_DID_LSB], didw);
         end
         `IID_G_11: begin
            c.match_did = 1'b1;
            c.domain_identifier = iid_mask_did(d[`IID_DID_MSB:`IID_DID_LSB], didw);
            c.sl_range = 1'b1;
            c.psc_sl = ~d[`IID_IH_BIT];
            c.addr = iid_mask_addr(d[`IID_ADDR_MSB:`IID_ADDR_LSB], max_guest_addr_width);
            c.am = d[`IID_AM_MSB:`IID_AM_LSB];
         end
         default: begin
            c.match_did = 1'b0;
         end
      endcase
      return c;
   endfunction : iid_dec_iotlb

   // First-level and nested command decode
   function automatic iid_inv_s iid_dec_ext(input iid_dsc_t d,
                                            input logic [4:0] didw,
                                            input logic [6:0] max_guest_addr_width);
      iid_inv_s c;
      c = '0;
      c.iotlb_fl = 1'b1;
      c.psc_fl = 1'b1;
      c.match_did = 1'b1;
      c.domain_identifier = iid_mask_did(d[`IID_DID_MSB:`IID_DID_LSB], didw);
      unique case (d[`IID_GRAN_MSB:`IID_GRAN_LSB])
         `IID_G_00: begin
            c.keep_global = 1'b0;
         end
         `IID_G_01: begin
            c.keep_global = 1'b1;
         end
         `IID_G_10: begin
            c.keep_global = 1'b1;
            c.match_pasid = 1'b1;
            c.pasid = d[`IID_PASID_MSB:`IID_PASID_LSB];
         end
         `IID_G_11: begin
            c.match_pasid = 1'b1;
            c.pasid = d[`IID_PASID_MSB:`IID_PASID_LSB];
            c.fl_range = 1'b1;
            c.keep_global = ~d[`IID_GL_BIT];
            c.psc_fl = ~d[`IID_IH_BIT];
            c.addr = d[`IID_ADDR_MSB:`IID_ADDR_LSB];
            c.am = d[`IID_AM_MSB:`IID_AM_LSB];
         end
      endcase
      return c;
   endfunction : iid_dec_ext

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [1:0] ctrl_r;
   logic [4:0] didw_r;
   logic [6:0] max_guest_addr_width_r;
   logic [15:0] done_count_r;
   logic [15:0] bad_count_r;
   iid_state_e state_r;
   iid_state_e state_nxt;
   iid_inv_s cmd_nxt;
   logic [3:0] dsc_type;
   logic dsc_known;
   logic dsc_take;
   logic wait_take;
   logic pend_rd_r;
   logic pend_wr_r;
   logic set_rd;
   logic set_wr;

   assign dsc_type = dsc_in[`IID_TYPE_MSB:`IID_TYPE_LSB];
   assign dsc_known = (dsc_type == `IID_TYPE_IOTLB && dsc_in[5:4] != `IID_G_00)
                      || dsc_type == `IID_TYPE_EXT;
   assign dsc_take = (state_r == ST_IDLE) && dsc_valid_in;
   assign wait_take = (state_r == ST_IDLE) && !dsc_valid_in && wait_valid_in;

   // Drain demands raised by accepted commands
   assign set_rd = dsc_take && dsc_known &&
                   (dsc_type == `IID_TYPE_EXT || dsc_in[`IID_DR_BIT]);
   assign set_wr = dsc_take && dsc_known &&
                   (dsc_type == `IID_TYPE_EXT || dsc_in[`IID_DW_BIT]);

   // Order for the caches, widened when coarse mode is set
   always_comb begin
      if (ctrl_r[`IID_CTRL_COARSE_BIT]) begin
         cmd_nxt = iid_all();
      end else if (dsc_type == `IID_TYPE_EXT) begin
         cmd_nxt = iid_dec_ext(dsc_in, didw_r, max_guest_addr_width_r);
      end else begin
         cmd_nxt = iid_dec_iotlb(dsc_in, didw_r, max_guest_addr_width_r);
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (dsc_take && dsc_known) begin
               if (ctrl_r[`IID_CTRL_WBF_BIT]) begin
                  state_nxt = ST_FLUSH;
               end else begin
                  state_nxt = ST_ISSUE;
               end
            end else if (wait_take && (pend_rd_r || pend_wr_r)) begin
               state_nxt = ST_DRAIN;
            end
         end
         ST_FLUSH: begin
            if (wbf_done_in) begin
               state_nxt = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (inv_ack_in) begin
               state_nxt = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (inv_quiesced_in) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_DRAIN: begin
            if (drain_done_in) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Ready towards the queue only when idle next
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         dsc_ready_out <= 1'b0;
         wait_ready_out <= 1'b0;
      end else begin
         dsc_ready_out <= (state_nxt == ST_IDLE);
         wait_ready_out <= (state_nxt == ST_IDLE);
      end
   end

   // Captured order and its valid until acknowledged
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         inv_cmd_out <= '0;
         inv_valid_out <= 1'b0;
      end else begin
         if (dsc_take && dsc_known) begin
            inv_cmd_out <= cmd_nxt;
         end
         inv_valid_out <= (state_nxt == ST_ISSUE);
      end
   end

   // Write-buffer flush pulse ahead of the order
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         wbf_req_out <= 1'b0;
      end else begin
         wbf_req_out <= (state_r == ST_IDLE) && (state_nxt == ST_FLUSH);
      end
   end

   // Owed drains; a new demand wins over the clear
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         pend_rd_r <= 1'b0;
         pend_wr_r <= 1'b0;
      end else begin
         if (set_rd) begin
            pend_rd_r <= 1'b1;
         end else if (state_r == ST_DRAIN && drain_done_in) begin
            pend_rd_r <= 1'b0;
         end
         if (set_wr) begin
            pend_wr_r <= 1'b1;
         end else if (state_r == ST_DRAIN && drain_done_in) begin
            pend_wr_r <= 1'b0;
         end
      end
   end

   // Drain request pulse with its kinds
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         drain_req_out <= 1'b0;
         drain_rd_out <= 1'b0;
         drain_wr_out <= 1'b0;
      end else begin
         drain_req_out <= (state_r == ST_IDLE) && (state_nxt == ST_DRAIN);
         if ((state_r == ST_IDLE) && (state_nxt == ST_DRAIN)) begin
            drain_rd_out <= pend_rd_r;
            drain_wr_out <= pend_wr_r;
         end
      end
   end

   // Wait completion only once drains and removal are done
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         wait_done_out <= 1'b0;
      end else begin
         wait_done_out <= (wait_take && !pend_rd_r && !pend_wr_r) ||
                          (state_r == ST_DRAIN && drain_done_in);
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   // Control and capability writes
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         ctrl_r <= `IID_CTRL_RESET;
         didw_r <= DIDW_RST;
         max_guest_addr_width_r <= MAX_GUEST_ADDR_WIDTH_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `IID_REG_CTRL) begin
            ctrl_r <= reg_wdata_in[1:0];
         end
         if (reg_addr_in == `IID_REG_CAP) begin
            didw_r <= reg_wdata_in[`IID_CAP_DIDW_MSB:`IID_CAP_DIDW_LSB];
            max_guest_addr_width_r <= reg_wdata_in[`IID_CAP_MAX_GUEST_ADDR_WIDTH_MSB:`IID_CAP_MAX_GUEST_ADDR_WIDTH_LSB];
         end
      end
   end

   // Completed and dropped command counters
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         done_count_r <= '0;
         bad_count_r <= '0;
      end else begin
         if (state_r == ST_SETTLE && inv_quiesced_in) begin
            done_count_r <= done_count_r + 16'h0001;
         end
         if (dsc_take && !dsc_known) begin
            bad_count_r <= bad_count_r + 16'h0001;
         end
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 32'h0;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `IID_REG_CTRL: reg_rdata_out <= {30'h0, ctrl_r};
            `IID_REG_STATUS: reg_rdata_out <= {27'h0, pend_wr_r, pend_rd_r,
                                              state_r};
            `IID_REG_CAP: reg_rdata_out <= {17'h0, max_guest_addr_width_r, 3'h0, didw_r};
            `IID_REG_COUNT: reg_rdata_out <= {bad_count_r, done_count_r};
            default: reg_rdata_out <= 32'h0;
         endcase
      end else begin
         reg_rdata_out <= 32'h0;
      end
   end

endmodule : iid_decoder

/* include/iid_cfg.svh */
`ifndef IID_CFG_SVH
`define IID_CFG_SVH
// ----------------------------------------
// Descriptor field positions
// ----------------------------------------
`define IID_TYPE_MSB 3
`define IID_TYPE_LSB 0
`define IID_GRAN_MSB 5
`define IID_GRAN_LSB 4
`define IID_DW_BIT 6
`define IID_DR_BIT 7
`define IID_DID_MSB 31
`define IID_DID_LSB 16
`define IID_PASID_MSB 51
`define IID_PASID_LSB 32
`define IID_AM_MSB 69
`define IID_AM_LSB 64
`define IID_IH_BIT 70
`define IID_GL_BIT 71
`define IID_ADDR_MSB 127
`define IID_ADDR_LSB 76
// ----------------------------------------
// Type and granularity codes
// ----------------------------------------
`define IID_TYPE_IOTLB 4'h2
`define IID_TYPE_EXT 4'h6
`define IID_G_00 2'h0
`define IID_G_01 2'h1
`define IID_G_10 2'h2
`define IID_G_11 2'h3
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define IID_REG_CTRL 4'h0
`define IID_REG_STATUS 4'h4
`define IID_REG_CAP 4'h8
`define IID_REG_COUNT 4'hc
`define IID_CTRL_WBF_BIT 0
`define IID_CTRL_COARSE_BIT 1
`define IID_CTRL_RESET 2'h0
`define IID_CAP_DIDW_MSB 4
`define IID_CAP_DIDW_LSB 0
`define IID_CAP_MAX_GUEST_ADDR_WIDTH_MSB 14
`define IID_CAP_MAX_GUEST_ADDR_WIDTH_LSB 8
`define IID_PAGE_SHIFT 12
`endif

/* include/iid_pkg.sv */
package iid_pkg;
   // ----------------------------------------
   // Types shared by the decoder
   // ----------------------------------------
   typedef logic [127:0] iid_dsc_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FLUSH,
      ST_ISSUE,
      ST_SETTLE,
      ST_DRAIN
   } iid_state_e;

   // One invalidation order towards the caches
   typedef struct packed {
      logic iotlb_sl;     // Second-level IOTLB entries
      logic iotlb_fl;     // First-level and nested IOTLB entries
      logic psc_sl;       // Second-level paging-structure entries
      logic psc_fl;       // First-level and nested paging-structure entries
      logic pasid_cache;  // PASID-cache entries
      logic match_did;    // Limit to domain
      logic match_pasid;  // Limit to process address space
      logic sl_range;     // Second-level entries limited to address range
      logic fl_range;     // First-level entries limited to address range
      logic keep_global;  // Global pages may be kept
      logic [15:0] domain_identifier;
      logic [19:0] pasid;
      logic [51:0] addr;
      logic [5:0] am;
   } iid_inv_s;
endpackage : iid_pkg

/* tb/iid_decoder_properties.sv */
`timescale 1ns/100ps
// ------------------------------
// Port checker for the decoder
// ------------------------------
module iid_props
   import iid_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic dsc_valid_in,
   input wire iid_dsc_t dsc_in,
   input wire logic dsc_ready_out,
   input wire logic wait_valid_in,
   input wire logic wait_done_out,
   input wire iid_inv_s inv_cmd_out,
   input wire logic inv_valid_out,
   input wire logic inv_ack_in,
   input wire logic inv_quiesced_in,
   input wire logic wbf_req_out,
   input wire logic drain_req_out,
   input wire logic drain_rd_out,
   input wire logic drain_wr_out,
   input wire logic drain_done_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in
);
   logic ext, known, take, wtake, wbf_en_r, owe_rd_r, owe_wr_r, in_drain_r;
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);
   // Command and wait handshakes
   assign ext = dsc_in[3:0] == 4'h6;
   assign known = ext || (dsc_in[3:0] == 4'h2 && dsc_in[5:4] != 2'h0);
   assign take = dsc_valid_in && dsc_ready_out;
   assign wtake = wait_valid_in && !dsc_valid_in && dsc_ready_out;
   // Flush enable, owed drains, drain in progress
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         wbf_en_r <= 1'b0;
         owe_rd_r <= 1'b0;
         owe_wr_r <= 1'b0;
         in_drain_r <= 1'b0;
      end else begin
         if (reg_wr_in && reg_addr_in == 4'h0) begin
            wbf_en_r <= reg_wdata_in[0];
         end
         owe_rd_r <= (owe_rd_r && !wait_done_out) || (take && known && (ext || dsc_in[7]));
         owe_wr_r <= (owe_wr_r && !wait_done_out) || (take && known && (ext || dsc_in[6]));
         in_drain_r <= (in_drain_r || drain_req_out) && !wait_done_out;
      end
   end
   a_drop_unknown: assert property (take && !known |=> dsc_ready_out && !inv_valid_out)
      else $error("unknown command not dropped");
   a_order_issue: assert property (take && known && !wbf_en_r |=> inv_valid_out)
      else $error("order not issued");
   a_flush_first: assert property (take && known && wbf_en_r |=>
      wbf_req_out && !inv_valid_out)
      else $error("flush not first");
   a_global_all: assert property (inv_valid_out && !inv_cmd_out.match_did |->
      &inv_cmd_out[103:99])
      else $error("unfiltered order misses a cache");
   a_order_hold: assert property (inv_valid_out && !inv_ack_in |=>
      inv_valid_out && $stable(inv_cmd_out))
      else $error("order dropped early");
   a_settle_ready: assert property (!dsc_ready_out && !inv_valid_out && !in_drain_r
      && inv_quiesced_in |=> dsc_ready_out)
      else $error("not idle after settle");
   a_wait_direct: assert property (wtake && !owe_rd_r && !owe_wr_r |=>
      wait_done_out && !drain_req_out)
      else $error("wait without drain late");
   a_drain_owed: assert property (wtake && (owe_rd_r || owe_wr_r) |=>
      drain_req_out && drain_rd_out == owe_rd_r && drain_wr_out == owe_wr_r)
      else $error("drain request wrong");
   a_drain_gate: assert property (in_drain_r && !drain_done_in |=> !wait_done_out)
      else $error("wait done before drain");
   a_drain_done: assert property (in_drain_r && drain_done_in |=>
      wait_done_out && dsc_ready_out)
      else $error("wait done missing");
   c_flush: cover property (take && known && wbf_en_r);
   c_drain_both: cover property (drain_req_out && drain_rd_out && drain_wr_out);
   c_drop: cover property (take && !known);
endmodule : iid_props

bind iid_decoder iid_props iid_props_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
   .dsc_valid_in(dsc_valid_in), .dsc_in(dsc_in), .dsc_ready_out(dsc_ready_out),
   .wait_valid_in(wait_valid_in), .wait_done_out(wait_done_out), .inv_cmd_out(inv_cmd_out),
   .inv_valid_out(inv_valid_out), .inv_ack_in(inv_ack_in), .inv_quiesced_in(inv_quiesced_in),
   .wbf_req_out(wbf_req_out), .drain_req_out(drain_req_out), .drain_rd_out(drain_rd_out),
   .drain_wr_out(drain_wr_out), .drain_done_in(drain_done_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in));

/* tb/iid_cache_model.sv */
`timescale 1ns/100ps
// Caches, write buffer and drain engine beside the decoder
module iid_cache_model (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic slow_in,
   input wire logic inv_valid_in,
   input wire logic wbf_req_in,
   input wire logic drain_req_in,
   output logic inv_ack_out,
   output logic inv_quiesced_out,
   output logic wbf_done_out,
   output logic drain_done_out
);
   // Response delay, none when fast
   function automatic int dly();
      return slow_in ? 1 + ($urandom % 6) : 0;
   endfunction : dly
   // Quiet outputs at start
   initial begin
      inv_ack_out = 1'b0;
      inv_quiesced_out = 1'b0;
      wbf_done_out = 1'b0;
      drain_done_out = 1'b0;
   end
   // Accept an order, then report it settled
   always begin
      @(posedge ref_clk_in);
      if (inv_valid_in && !reset_in) begin
         repeat (dly()) @(posedge ref_clk_in);
         inv_ack_out <= 1'b1;
         @(posedge ref_clk_in);
         inv_ack_out <= 1'b0;
         repeat (dly() + 1) @(posedge ref_clk_in);
         inv_quiesced_out <= 1'b1;
         @(posedge ref_clk_in);
         inv_quiesced_out <= 1'b0;
      end
   end
   // Write buffer flush
   always begin
      @(posedge ref_clk_in);
      if (wbf_req_in && !reset_in) begin
         repeat (dly()) @(posedge ref_clk_in);
         wbf_done_out <= 1'b1;
         @(posedge ref_clk_in);
         wbf_done_out <= 1'b0;
      end
   end
   // Read and write drain
   always begin
      @(posedge ref_clk_in);
      if (drain_req_in && !reset_in) begin
         repeat (dly()) @(posedge ref_clk_in);
         drain_done_out <= 1'b1;
         @(posedge ref_clk_in);
         drain_done_out <= 1'b0;
      end
   end
endmodule : iid_cache_model

/* tb/iotlb_invalidation_decoder_tb.sv */
`timescale 1ns/100ps
`include "iid_cfg.svh"
module iotlb_invalidation_decoder_tb
   import iid_pkg::*;
();
   localparam int DIDW = 8;
   localparam int MAX_GUEST_ADDR_WIDTH = 39;
   localparam logic [15:0] DMASK = 16'h00ff;
   localparam logic [51:0] AMASK = (52'h1 << (MAX_GUEST_ADDR_WIDTH - 12)) - 52'h1;
   logic ref_clk_in, reset_in, dsc_valid_in, wait_valid_in, inv_ack_in, inv_quiesced_in;
   logic wbf_done_in, drain_done_in, reg_wr_in, reg_rd_in, slow;
   logic dsc_ready_out, wait_ready_out, wait_done_out, inv_valid_out, wbf_req_out;
   logic drain_req_out, drain_rd_out, drain_wr_out;
   logic [3:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out;
   iid_dsc_t dsc_in;
   iid_inv_s inv_cmd_out, s, x;
   iid_inv_s cmd_q[$];
   logic [127:0] drain_q[$];
   logic [31:0] rd_q[$], rdm_q[$];
   int err_total = 0, num_checks = 0, wbf_cnt = 0, done_cnt = 0, w0;
   logic rd_pend = 1'b0, inv_prev = 1'b0, coarse = 1'b0;
   // Clock
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   iid_decoder #(.DID_WIDTH_DEF(DIDW), .MAX_GUEST_ADDR_WIDTH_DEF(MAX_GUEST_ADDR_WIDTH)) iid_decoder_inst (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .dsc_valid_in(dsc_valid_in),
      .dsc_in(dsc_in), .dsc_ready_out(dsc_ready_out), .wait_valid_in(wait_valid_in),
      .wait_ready_out(wait_ready_out), .wait_done_out(wait_done_out),
      .inv_cmd_out(inv_cmd_out), .inv_valid_out(inv_valid_out), .inv_ack_in(inv_ack_in),
      .inv_quiesced_in(inv_quiesced_in), .wbf_req_out(wbf_req_out), .wbf_done_in(wbf_done_in),
      .drain_req_out(drain_req_out), .drain_rd_out(drain_rd_out), .drain_wr_out(drain_wr_out),
      .drain_done_in(drain_done_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
   iid_cache_model iid_cache_model_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .slow_in(slow), .inv_valid_in(inv_valid_out), .wbf_req_in(wbf_req_out),
      .drain_req_in(drain_req_out), .inv_ack_out(inv_ack_in),
      .inv_quiesced_out(inv_quiesced_in), .wbf_done_out(wbf_done_in),
      .drain_done_out(drain_done_in));
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   // Expected cache order for a command
   function automatic iid_inv_s exp_of(input iid_dsc_t d);
      iid_inv_s e;
      logic [1:0] g;
      e = '0;
      g = d[5:4];
      if (coarse) begin
         e[103:99] = 5'h1f;
      end else if (d[3:0] == `IID_TYPE_IOTLB) begin
         e[103:99] = 5'h1f;
         e.match_did = (g != 2'h1);
         e.domain_identifier = e.match_did ? d[31:16] & DMASK : 16'h0000;
         if (g == 2'h3) begin
            e.psc_sl = !d[70];
            e.sl_range = 1'b1;
            e.addr = d[127:76] & AMASK;
            e.am = d[69:64];
         end
      end else begin
         e.iotlb_fl = 1'b1;
         e.psc_fl = 1'b1;
         e.match_did = 1'b1;
         e.domain_identifier = d[31:16] & DMASK;
         e.keep_global = (g != 2'h0);
         e.match_pasid = g[1];
         e.pasid = g[1] ? d[51:32] : 20'h00000;
         if (g == 2'h3) begin
            e.psc_fl = !d[70];
            e.fl_range = 1'b1;
            e.keep_global = !d[71];
            e.addr = d[127:76];
            e.am = d[69:64];
         end
      end
      return e;
   endfunction : exp_of
   // Random command with reserved bits clear
   function automatic iid_dsc_t rnd(input logic [3:0] t, input logic [1:0] g,
                                    input logic [1:0] drw);
      iid_dsc_t d;
      d = {$urandom, $urandom, $urandom, $urandom};
      d[15:0] = {8'h00, drw, g, t};
      d[63:52] = 12'h000;
      d[75:64] = {4'h0, d[71:70], 6'(9 * ($urandom % 3))};
      return d;
   endfunction : rnd
   task automatic wait_idle();
      int n = 0;
      @(posedge ref_clk_in);
      while (dsc_ready_out !== 1'b1 && n < 300) begin
         @(posedge ref_clk_in);
         n++;
      end
      if (n >= 300) check(128'h0, 128'h1, "stuck busy");
   endtask : wait_idle
   task automatic send(input iid_dsc_t d, input bit known);
      if (known) cmd_q.push_back(exp_of(d));
      dsc_in <= d;
      dsc_valid_in <= 1'b1;
      wait_idle();
      dsc_valid_in <= 1'b0;
      wait_idle();
   endtask : send
   task automatic do_wait(input logic [1:0] dr);
      int n = 0;
      int c = done_cnt;
      if (dr != 2'b00) drain_q.push_back(128'(dr));
      wait_valid_in <= 1'b1;
      wait_idle();
      wait_valid_in <= 1'b0;
      while (done_cnt == c && n < 300) begin
         @(posedge ref_clk_in);
         n++;
      end
      check(128'(done_cnt - c), 128'h1, "wait done");
      wait_idle();
   endtask : do_wait
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
      rd_q.push_back(exp);
      rdm_q.push_back(m);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask : reg_rd
   // Watch outputs against the oldest note
   always @(posedge ref_clk_in) begin
      if (rd_pend) begin
         check(128'(reg_rdata_out & rdm_q.pop_front()), 128'(rd_q.pop_front()), "rd");
      end
      rd_pend = reg_rd_in;
      if (inv_valid_out && !inv_prev) begin
         s = inv_cmd_out;
         x = cmd_q.pop_front();
         check(128'(s[103:99]), 128'(x[103:99]), "caches");
         check(128'(s[98:94]), 128'(x[98:94]), "filters");
         check(128'(s[93:0]), 128'(x[93:0]), "fields");
      end
      inv_prev = inv_valid_out;
      check(128'(wait_ready_out), 128'(dsc_ready_out), "wait ready");
      if (drain_req_out) begin
         check(128'({drain_rd_out, drain_wr_out}), drain_q.pop_front(), "drain");
      end
      if (wbf_req_out) wbf_cnt++;
      if (wait_done_out) done_cnt++;
   end
   // Main sequence
   initial begin
      void'($urandom(85863));
      {reset_in, dsc_valid_in, wait_valid_in, reg_wr_in, reg_rd_in, slow} = 6'h20;
      {dsc_in, reg_addr_in, reg_wdata_in} = '0;
      repeat (5) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      @(posedge ref_clk_in);
      reg_rd(`IID_REG_CTRL, 32'h0, 32'hffffffff);
      reg_rd(`IID_REG_CAP, {17'h0, 7'(MAX_GUEST_ADDR_WIDTH), 3'h0, 5'(DIDW)}, 32'h00007f1f);
      reg_wr(4'h2, 32'hffffffff);
      reg_rd(4'h2, 32'h0, 32'hffffffff);
      wait_idle();
      for (int g = 1; g < 4; g++) begin
         repeat (4) send(rnd(`IID_TYPE_IOTLB, 2'(g), 2'b00), 1'b1);
      end
      slow <= 1'b1;
      for (int g = 0; g < 4; g++) begin
         repeat (4) send(rnd(`IID_TYPE_EXT, 2'(g), 2'b00), 1'b1);
      end
      do_wait(2'b11);
      slow <= 1'b0;
      for (int f = 0; f < 4; f++) begin
         send(rnd(`IID_TYPE_IOTLB, 2'h2, 2'(f)), 1'b1);
         do_wait(2'(f));
      end
      send(rnd(`IID_TYPE_IOTLB, 2'h0, 2'b00), 1'b0);
      send(rnd(4'h5, 2'h2, 2'b00), 1'b0);
      reg_rd(`IID_REG_COUNT, 32'h00020020, 32'hffffffff);
      reg_wr(`IID_REG_CTRL, 32'h1);
      reg_rd(`IID_REG_CTRL, 32'h1, 32'h1);
      w0 = wbf_cnt;
      slow <= 1'b1;
      send(rnd(`IID_TYPE_IOTLB, 2'h3, 2'b00), 1'b1);
      send(rnd(`IID_TYPE_EXT, 2'h1, 2'b00), 1'b1);
      check(128'(wbf_cnt - w0), 128'h2, "flush count");
      reg_rd(`IID_REG_STATUS, 32'h00000018, 32'hffffffff);
      do_wait(2'b11);
      coarse = 1'b1;
      reg_wr(`IID_REG_CTRL, 32'h2);
      send(rnd(`IID_TYPE_IOTLB, 2'h3, 2'b00), 1'b1);
      do_wait(2'b00);
      wrap_up();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      err_total++;
      wrap_up();
   end
endmodule : iotlb_invalidation_decoder_tb
